// ===== design/sas_top.sv
// Control shell of the security subsystem: cipher, hash and public key
// engine sequencing, public key work memory, random bits, monotonic counter.
// Assumes all inputs except entropy_raw come from logic on clk_sys.
//
// Behaviour
// - Public key engine raises a fault event on a core fault.
// - Public key engine raises a completion event when an operation ends without a core fault.
// - Cipher engine raises a completion event when its job finishes.
// - Random generator raises an event when its bit buffer becomes full.
// - Random bits are precomputed into a buffer of one kilobit.
// - Cipher encrypts and decrypts with 128, 192 and 256 bit keys.
// - Cipher modes ECB, CBC, CTR, OFB and CFB are accepted.
// - Hash computes SHA-1, SHA-224, SHA-256, SHA-384 and SHA-512.
// - RSA encrypt and decrypt with 1024, 2048, 3072, 4096 bit moduli.
// - Point multiply on all NIST curves, binary and prime fields.
// - Point multiply and Edwards signatures on Curve25519.
// - ECDSA and Korean certificate signatures on every NIST curve.
// - 24KB work memory reachable by the processor only while engine idle.
// - Public key engine runs from its private memory without the processor.
// - Monotonic counter increments on each access while battery holds.
// - High word register combines with the counter into 64 bits.
// - System reset returns all registers to defaults, except the monotonic counter and the memories.
// - Low power state is entered on request from the power unit.
`timescale 1ns/1ns
module sas_top
  import sas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic battery_reset,
  input wire logic cipher_start,
  input wire sas_cipher_cfg_t cipher_cfg,
  output logic cipher_busy,
  input wire logic hash_start,
  input wire sas_hash_t hash_alg,
  output logic hash_busy,
  input wire logic pk_start,
  input wire sas_pk_op_t pk_op,
  input wire logic pk_core_fault,
  output logic pk_busy,
  output logic cmd_reject,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic mem_err,
  output logic [31:0] mem_rdata,
  input wire logic rng_enable,
  input wire logic entropy_raw,
  input wire logic rng_rd,
  output logic rng_valid,
  output logic [31:0] rng_word,
  input wire logic ctr_access,
  input wire logic ctr_hi_wr,
  input wire logic [31:0] ctr_hi_wdata,
  output logic [63:0] ctr_value,
  input wire logic lp_req,
  output logic lp_ack,
  input wire logic [SAS_EVT_N-1:0] evt_clear,
  output logic [SAS_EVT_N-1:0] evt_flags
);

  // ************************************************************
  // Command checking
  // ************************************************************
  sas_pk_state_t pk_state;
  sas_pk_state_t next_pk_state;
  wire cipher_cfg_ok = (cipher_cfg.key_len != 2'h3) &&
    (cipher_cfg.mode <= SAS_MODE_CFB);
  wire hash_ok = (hash_alg <= SAS_SHA512);
  wire pk_rsa = (pk_op.alg == SAS_PK_RSA_ENC) || (pk_op.alg == SAS_PK_RSA_DEC);
  wire pk_nist = (pk_op.alg == SAS_PK_EC_MUL) || (pk_op.alg == SAS_PK_ECDSA) ||
    (pk_op.alg == SAS_PK_KCDSA);
  wire pk_size_ok = pk_rsa ? (pk_op.size < SAS_RSA_SIZES) :
    pk_nist ? (pk_op.size < SAS_NIST_CURVES) : 1'b1;
  wire can_start = !lp_ack && !lp_req;

  wire cipher_go = cipher_start && !cipher_busy && cipher_cfg_ok && can_start;
  wire hash_go = hash_start && !hash_busy && hash_ok && can_start;
  wire pk_idle = (pk_state == SAS_PK_IDLE);
  wire pk_go = pk_start && pk_idle && pk_size_ok && can_start;
  wire any_reject = (cipher_start && !cipher_go) || (hash_start && !hash_go) ||
    (pk_start && !pk_go);

  // ************************************************************
  // Latency selection
  // ************************************************************
  wire [11:0] cipher_lat = (cipher_cfg.key_len == SAS_KEY_128) ? SAS_LAT_AES128 :
    (cipher_cfg.key_len == SAS_KEY_192) ? SAS_LAT_AES192 : SAS_LAT_AES256;
  wire [11:0] hash_lat = (hash_alg == SAS_SHA1) ? SAS_LAT_SHA1 :
    (hash_alg >= SAS_SHA384) ? SAS_LAT_SHA_LARGE : SAS_LAT_SHA_SMALL;
  wire [11:0] pk_lat = pk_rsa ? (SAS_LAT_PK_BASE << pk_op.size[1:0]) :
    SAS_LAT_EC + {7'h00, pk_op.binary_field, 4'h0};

  // ************************************************************
  // Cipher and hash engine sequencing
  // ************************************************************
  logic [11:0] cipher_cnt;
  logic [11:0] hash_cnt;
  logic cipher_dir;
  sas_mode_t cipher_mode;
  sas_hash_t hash_cur;

  wire cipher_end = cipher_busy && (cipher_cnt == 12'h001);
  wire hash_end = hash_busy && (hash_cnt == 12'h001);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cipher_busy <= 1'b0;
      cipher_cnt <= 12'h000;
      cipher_dir <= 1'b0;
      cipher_mode <= SAS_MODE_ECB;
    end else if (cipher_go) begin
      cipher_busy <= 1'b1;
      cipher_cnt <= cipher_lat;
      cipher_dir <= cipher_cfg.encrypt;
      cipher_mode <= cipher_cfg.mode;
    end else if (cipher_busy) begin
      cipher_cnt <= cipher_cnt - 12'h001;
      cipher_busy <= !cipher_end;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hash_busy <= 1'b0;
      hash_cnt <= 12'h000;
      hash_cur <= SAS_SHA1;
    end else if (hash_go) begin
      hash_busy <= 1'b1;
      hash_cnt <= hash_lat;
      hash_cur <= hash_alg;
    end else if (hash_busy) begin
      hash_cnt <= hash_cnt - 12'h001;
      hash_busy <= !hash_end;
    end
  end

  // ************************************************************
  // Public key engine sequencing
  // ************************************************************
  logic [11:0] pk_cnt;
  logic pk_failed;

  wire pk_run_end = (pk_state == SAS_PK_RUN) && ((pk_cnt == 12'h001) || pk_core_fault);

  always_comb begin
    next_pk_state = pk_state;
    case (pk_state)
      SAS_PK_IDLE: begin
        if (pk_go) begin
          next_pk_state = SAS_PK_RUN;
        end
      end
      SAS_PK_RUN: begin
        if (pk_run_end) begin
          next_pk_state = SAS_PK_END;
        end
      end
      SAS_PK_END: begin
        next_pk_state = SAS_PK_IDLE;
      end
      default: begin
        next_pk_state = SAS_PK_IDLE;
      end
    endcase
  end

  // Engine runs on its own once started; the processor is locked out
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pk_state <= SAS_PK_IDLE;
      pk_cnt <= 12'h000;
      pk_failed <= 1'b0;
    end else begin
      pk_state <= next_pk_state;
      if (pk_go) begin
        pk_cnt <= pk_lat;
        pk_failed <= 1'b0;
      end else if (pk_state == SAS_PK_RUN) begin
        pk_cnt <= pk_cnt - 12'h001;
        pk_failed <= pk_core_fault;
      end
    end
  end

  assign pk_busy = !pk_idle;
  wire pk_done_pulse = (pk_state == SAS_PK_END) && !pk_failed;
  wire pk_fault_pulse = (pk_state == SAS_PK_END) && pk_failed;

  // ************************************************************
  // Work memory, shared with the engine
  // ************************************************************
  logic [31:0] pk_mem [0:SAS_PK_MEM_WORDS-1];
  wire mem_in_range = (mem_addr >= SAS_PK_MEM_BASE) && (mem_addr <= SAS_PK_MEM_END);
  wire [31:0] mem_off = mem_addr - SAS_PK_MEM_BASE;
  wire [SAS_PK_AW-1:0] mem_idx = mem_off[SAS_PK_AW+1:2];
  wire mem_grant = mem_req && mem_in_range && pk_idle;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      mem_ack <= mem_grant;
      mem_err <= mem_req && !mem_grant;
      if (mem_grant && !mem_we) begin
        mem_rdata <= pk_mem[mem_idx];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mem_grant && mem_we) begin
      pk_mem[mem_idx] <= mem_wdata;
    end
  end

  // ************************************************************
  // Random bits
  // ************************************************************
  logic entropy_meta;
  logic entropy_sync;
  logic [3:0] rng_div;
  logic rng_full;
  logic rng_full_d;
  logic rng_bit_ready;

  wire rng_tick = (rng_div == SAS_RNG_DIV);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      entropy_meta <= 1'b0;
      entropy_sync <= 1'b0;
      rng_div <= 4'h0;
      rng_full_d <= 1'b0;
    end else begin
      entropy_meta <= entropy_raw;
      entropy_sync <= entropy_meta;
      rng_div <= rng_tick ? 4'h0 : rng_div + 4'h1;
      rng_full_d <= rng_full;
    end
  end

  sas_bit_fifo u_rng_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .bit_valid(rng_tick && rng_enable && !lp_ack),
    .bit_in(entropy_sync),
    .bit_ready(rng_bit_ready),
    .full(rng_full),
    .word_valid(rng_valid),
    .word_ready(rng_rd),
    .word(rng_word)
  );

  wire rng_full_pulse = rng_full && !rng_full_d;

  // ************************************************************
  // Monotonic counter
  // ************************************************************
  sas_mono_ctr u_mono_ctr (
    .clk_sys(clk_sys),
    .battery_reset(battery_reset),
    .access(ctr_access),
    .hi_wr(ctr_hi_wr),
    .hi_wdata(ctr_hi_wdata),
    .low_word(),
    .hi_word(),
    .value(ctr_value)
  );

  // ************************************************************
  // Low power and sticky events
  // ************************************************************
  wire all_idle = !cipher_busy && !hash_busy && pk_idle;
  wire [SAS_EVT_N-1:0] evt_set = {rng_full_pulse, hash_end, cipher_end,
    pk_done_pulse, pk_fault_pulse};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lp_ack <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      lp_ack <= lp_req && all_idle;
      cmd_reject <= any_reject;
    end
  end

  // Set beats clear so no event is lost in the clearing cycle
  genvar gi;
  generate
    for (gi = 0; gi < SAS_EVT_N; gi++) begin : g_evt
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          evt_flags[gi] <= 1'b0;
        end else if (evt_set[gi]) begin
          evt_flags[gi] <= 1'b1;
        end else if (evt_clear[gi]) begin
          evt_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Checks
  // ************************************************************
  chk_pk_mem_locked: assert property (@(posedge clk_sys) disable iff (reset)
    (mem_req && pk_busy) |=> (mem_err && !mem_ack))
    else $error("Work memory reached while engine busy");

  chk_pk_fault_event: assert property (@(posedge clk_sys) disable iff (reset)
    ((pk_state == SAS_PK_RUN) && pk_core_fault) |=> ##1 evt_flags[SAS_EVT_PK_FAULT])
    else $error("Core fault raised no fault event");

  chk_pk_done_event: assert property (@(posedge clk_sys) disable iff (reset)
    (pk_done_pulse) |=> evt_flags[SAS_EVT_PK_DONE])
    else $error("Public key completion not flagged");

  chk_cipher_latency: assert property (@(posedge clk_sys) disable iff (reset)
    (cipher_go && cipher_cfg.key_len == SAS_KEY_128) |=> cipher_busy [*5] ##1
      cipher_busy [*5] ##1 (!cipher_busy && evt_flags[SAS_EVT_CIPHER_DONE]))
    else $error("Cipher 128 job wrong length or no event");

  chk_hash_done_event: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(hash_busy) |-> evt_flags[SAS_EVT_HASH_DONE])
    else $error("Hash completion not flagged");

  chk_rng_full_event: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(rng_full) |=> evt_flags[SAS_EVT_RNG_FULL])
    else $error("Full bit buffer raised no event");

  chk_evt_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    (evt_flags[SAS_EVT_PK_DONE] && !evt_clear[SAS_EVT_PK_DONE]) |=>
      evt_flags[SAS_EVT_PK_DONE])
    else $error("Event flag dropped without clear");

  chk_lp_no_start: assert property (@(posedge clk_sys) disable iff (reset)
    (lp_ack && (cipher_start || hash_start || pk_start)) |=> cmd_reject)
    else $error("Start accepted in low power state");

  chk_bad_key_refused: assert property (@(posedge clk_sys) disable iff (reset)
    (cipher_start && cipher_cfg.key_len == 2'h3 && !cipher_busy) |=> !cipher_busy)
    else $error("Invalid key length accepted");

  chk_reset_clears: assert property (@(posedge clk_sys)
    reset |=> (evt_flags == '0 && !pk_busy && !cipher_busy && !hash_busy))
    else $error("Reset left state behind");

endmodule // sas_top

// ===== design/sas_pkg.sv
// Shared constants and types of the security subsystem control shell.
// Assumes one 25 MHz clock and a synchronous active-high reset.
package sas_pkg;

  // ************************************************************
  // Work memory map
  // ************************************************************
  localparam int SAS_PK_MEM_WORDS = 6144;
  localparam int SAS_PK_AW = 13;
  localparam logic [31:0] SAS_PK_MEM_BASE = 32'h4010_0000;
  localparam logic [31:0] SAS_PK_MEM_END = 32'h4010_5FFF;

  // ************************************************************
  // Event flag positions
  // ************************************************************
  localparam int SAS_EVT_N = 5;
  localparam int SAS_EVT_PK_FAULT = 0;
  localparam int SAS_EVT_PK_DONE = 1;
  localparam int SAS_EVT_CIPHER_DONE = 2;
  localparam int SAS_EVT_HASH_DONE = 3;
  localparam int SAS_EVT_RNG_FULL = 4;

  // ************************************************************
  // Random bit buffer and counters
  // ************************************************************
  localparam int SAS_RNG_BITS = 1024;
  localparam int SAS_RNG_WORDS = SAS_RNG_BITS / 32;
  localparam int SAS_RNG_CW = 6;
  localparam logic [3:0] SAS_RNG_DIV = 4'h7;
  localparam logic [31:0] SAS_CTR_RESET = 32'h0000_0000;

  // ************************************************************
  // Engine latencies in clock cycles
  // ************************************************************
  localparam logic [11:0] SAS_LAT_AES128 = 12'h00A;
  localparam logic [11:0] SAS_LAT_AES192 = 12'h00C;
  localparam logic [11:0] SAS_LAT_AES256 = 12'h00E;
  localparam logic [11:0] SAS_LAT_SHA_SMALL = 12'h040;
  localparam logic [11:0] SAS_LAT_SHA_LARGE = 12'h050;
  localparam logic [11:0] SAS_LAT_SHA1 = 12'h050;
  localparam logic [11:0] SAS_LAT_PK_BASE = 12'h100;
  localparam logic [11:0] SAS_LAT_EC = 12'h200;

  // ************************************************************
  // Operation encodings
  // ************************************************************
  typedef enum logic [1:0] {
    SAS_KEY_128 = 2'h0, SAS_KEY_192 = 2'h1, SAS_KEY_256 = 2'h2
  } sas_key_t;

  typedef enum logic [2:0] {
    SAS_MODE_ECB = 3'h0, SAS_MODE_CBC = 3'h1, SAS_MODE_CTR = 3'h2,
    SAS_MODE_OFB = 3'h3, SAS_MODE_CFB = 3'h4
  } sas_mode_t;

  typedef enum logic [2:0] {
    SAS_SHA1 = 3'h0, SAS_SHA224 = 3'h1, SAS_SHA256 = 3'h2,
    SAS_SHA384 = 3'h3, SAS_SHA512 = 3'h4
  } sas_hash_t;

  typedef enum logic [2:0] {
    SAS_PK_RSA_ENC = 3'h0, SAS_PK_RSA_DEC = 3'h1, SAS_PK_EC_MUL = 3'h2,
    SAS_PK_X25519 = 3'h3, SAS_PK_ECDSA = 3'h4, SAS_PK_KCDSA = 3'h5,
    SAS_PK_EDDSA = 3'h6, SAS_PK_PRIME = 3'h7
  } sas_pk_alg_t;

  typedef enum logic [1:0] {
    SAS_PK_IDLE = 2'h0, SAS_PK_RUN = 2'h1, SAS_PK_END = 2'h2
  } sas_pk_state_t;

  // Size: RSA modulus index 0..3 = 1024/2048/3072/4096; EC curve index 0..4
  localparam logic [2:0] SAS_RSA_SIZES = 3'h4;
  localparam logic [2:0] SAS_NIST_CURVES = 3'h5;

  typedef struct packed {
    logic encrypt;
    sas_key_t key_len;
    sas_mode_t mode;
  } sas_cipher_cfg_t;

  typedef struct packed {
    sas_pk_alg_t alg;
    logic binary_field;
    logic [2:0] size;
  } sas_pk_op_t;

endpackage

// ===== design/sas_bit_fifo.sv
// Random bit buffer: packs single bits into words and stores them.
// Assumes bits arrive on the system clock, one per enabled cycle.
`timescale 1ns/1ns
module sas_bit_fifo
  import sas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic bit_valid,
  input wire logic bit_in,
  output logic bit_ready,
  output logic full,
  output logic word_valid,
  input wire logic word_ready,
  output logic [31:0] word
);

  logic [31:0] mem [0:SAS_RNG_WORDS-1];
  logic [31:0] acc;
  logic [4:0] acc_n;
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  logic [SAS_RNG_CW-1:0] count;

  wire take_bit = bit_valid && bit_ready;
  wire push = take_bit && (acc_n == 5'h1F);
  wire pop = word_valid && word_ready;

  assign bit_ready = (count < 6'(SAS_RNG_WORDS));
  assign full = (count == 6'(SAS_RNG_WORDS));
  assign word_valid = (count != 6'h00);
  assign word = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc <= 32'h0000_0000;
      acc_n <= 5'h00;
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      count <= 6'h00;
    end else begin
      if (take_bit) begin
        acc <= {acc[30:0], bit_in};
        acc_n <= acc_n + 5'h01;
      end
      if (push) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
      count <= count + {5'h00, push} - {5'h00, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= {acc[30:0], bit_in};
    end
  end

  chk_fifo_never_over: assert property (@(posedge clk_sys) disable iff (reset)
    count <= 6'(SAS_RNG_WORDS)) else $error("Bit buffer over capacity");

endmodule // sas_bit_fifo

// ===== design/sas_mono_ctr.sv
// Monotonic counter with its software-kept high word.
// Assumes the battery reset arrives as a level on the system clock.
`timescale 1ns/1ns
module sas_mono_ctr
  import sas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic battery_reset,
  input wire logic access,
  input wire logic hi_wr,
  input wire logic [31:0] hi_wdata,
  output logic [31:0] low_word,
  output logic [31:0] hi_word,
  output logic [63:0] value
);

  logic [31:0] count;

  // System reset does not touch this: it lives as long as battery power does
  always_ff @(posedge clk_sys) begin
    if (battery_reset) begin
      count <= SAS_CTR_RESET;
      hi_word <= SAS_CTR_RESET;
      low_word <= SAS_CTR_RESET;
    end else begin
      if (access) begin
        low_word <= count;
        count <= count + 32'h0000_0001;
      end
      if (hi_wr) begin
        hi_word <= hi_wdata;
      end
    end
  end

  assign value = {hi_word, low_word};

  chk_ctr_steps_up: assert property (@(posedge clk_sys) disable iff (battery_reset)
    access |=> (count == $past(count) + 32'h0000_0001))
    else $error("Counter did not step on access");

endmodule // sas_mono_ctr

// ===== dv/sas_cpu_model.sv
// Processor side of the work memory port: one-cycle requests.
// Assumes answers arrive on the edge after each request.
`timescale 1ns/1ns
module sas_cpu_model
  import sas_pkg::*;
(
  input wire logic clk_sys,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata
);
  // ****************************************
  // Access sequence
  // ****************************************
  initial begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = 32'h0;
    mem_wdata = 32'h0;
  end

  task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d,
                        output logic [1:0] rsp, output logic [31:0] q);
    @(posedge clk_sys);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk_sys);
    mem_req <= 1'b0;
    // Released lines must not keep showing the old value
    mem_addr <= ~a;
    mem_wdata <= ~d;
    #1;
    rsp = {mem_err, mem_ack};
    q = mem_rdata;
  endtask
endmodule // sas_cpu_model

// ===== dv/tb.sv
// Scenario bench for the security subsystem control shell.
// Assumes the memory port is driven by the processor model.
`timescale 1ns/1ns
module tb
  import sas_pkg::*;
;
  logic clk_sys = 1'b0, reset = 1'b1, battery_reset = 1'b1;
  logic cipher_start = 1'b0, hash_start = 1'b0, pk_start = 1'b0, pk_core_fault = 1'b0;
  sas_cipher_cfg_t cipher_cfg = '0;
  sas_hash_t hash_alg = SAS_SHA1;
  sas_pk_op_t pk_op = '0;
  logic rng_enable = 1'b0, entropy_raw = 1'b0, rng_rd = 1'b0, ctr_access = 1'b0;
  logic ctr_hi_wr = 1'b0, lp_req = 1'b0;
  logic [31:0] ctr_hi_wdata = 32'h0;
  logic [4:0] evt_clear = 5'h0;
  logic cipher_busy, hash_busy, pk_busy, cmd_reject, mem_ack, mem_err, rng_valid, lp_ack;
  logic mem_req, mem_we;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, rng_word;
  logic [63:0] ctr_value;
  logic [4:0] evt_flags;
  logic [1:0] rsp;
  logic [31:0] q;
  int err_count = 0, tests_run = 0, n;
  wire [2:0] bz = {pk_busy, hash_busy, cipher_busy};

  always #20 clk_sys = ~clk_sys;
  logic [3:0] ent_cnt = 4'h0;

  // Flips every 8 cycles so successive sampled bits alternate
  always @(posedge clk_sys) begin
    ent_cnt <= ent_cnt + 4'h1;
    entropy_raw <= ent_cnt[3];
  end

  sas_top i_sas_top (.clk_sys(clk_sys), .reset(reset), .battery_reset(battery_reset),
    .cipher_start(cipher_start), .cipher_cfg(cipher_cfg), .cipher_busy(cipher_busy),
    .hash_start(hash_start), .hash_alg(hash_alg), .hash_busy(hash_busy),
    .pk_start(pk_start), .pk_op(pk_op), .pk_core_fault(pk_core_fault), .pk_busy(pk_busy),
    .cmd_reject(cmd_reject), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
    .rng_enable(rng_enable), .entropy_raw(entropy_raw), .rng_rd(rng_rd),
    .rng_valid(rng_valid), .rng_word(rng_word), .ctr_access(ctr_access),
    .ctr_hi_wr(ctr_hi_wr), .ctr_hi_wdata(ctr_hi_wdata), .ctr_value(ctr_value),
    .lp_req(lp_req), .lp_ack(lp_ack), .evt_clear(evt_clear), .evt_flags(evt_flags));

  sas_cpu_model i_sas_cpu_model (.clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic go(input int s);
    @(posedge clk_sys);
    if (s == 0) cipher_start <= 1'b1;
    else if (s == 1) hash_start <= 1'b1;
    else pk_start <= 1'b1;
    @(posedge clk_sys);
    cipher_start <= 1'b0;
    hash_start <= 1'b0;
    pk_start <= 1'b0;
  endtask

  // Busy cycles of engine s, ending just after busy falls
  task automatic cnt(input int s, output int k);
    k = 0;
    #1;
    while (bz[s] === 1'b1 && k < 3000) begin
      k++;
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic clr(input logic [4:0] exp);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(evt_flags, exp);
    @(posedge clk_sys);
    evt_clear <= 5'h1F;
    @(posedge clk_sys);
    evt_clear <= 5'h0;
    #1;
    chk(evt_flags, 5'h0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_ctr();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      ctr_access <= 1'b1;
      ctr_hi_wr <= (i == 1);
      ctr_hi_wdata <= 32'h0000_0005;
      @(posedge clk_sys);
      ctr_access <= 1'b0;
      ctr_hi_wr <= 1'b0;
      #1;
      chk(ctr_value[31:0], i);
    end
    chk(ctr_value, 64'h0000_0005_0000_0002);
  endtask

  task automatic t_cipher();
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      cipher_cfg <= {i[0], sas_key_t'(i % 3), sas_mode_t'(i)};
      go(0);
      if (i == 5) begin
        #1;
        chk(cmd_reject, 1'b1);
      end else begin
        cnt(0, n);
        chk(n, 10 + 2 * (i % 3));
        clr(5'h04);
      end
    end
  endtask

  task automatic t_hash();
    int lat[5] = '{80, 64, 64, 80, 80};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      hash_alg <= sas_hash_t'(i);
      go(1);
      if (i == 5) begin
        #1;
        chk({cmd_reject, hash_busy}, 2'b10);
      end else begin
        cnt(1, n);
        chk(n, lat[i]);
        clr(5'h08);
      end
    end
  endtask

  task automatic t_pk();
    @(posedge clk_sys);
    pk_op <= {SAS_PK_RSA_ENC, 1'b0, 3'h0};
    go(2);
    cnt(2, n);
    chk(n, 257);
    clr(5'h02);
    @(posedge clk_sys);
    pk_op <= {SAS_PK_EC_MUL, 1'b1, 3'h4};
    go(2);
    cnt(2, n);
    chk(n, 529);
    clr(5'h02);
    @(posedge clk_sys);
    pk_op <= {SAS_PK_KCDSA, 1'b0, 3'h5};
    go(2);
    #1;
    chk({cmd_reject, pk_busy}, 2'b10);
    @(posedge clk_sys);
    pk_op <= {SAS_PK_X25519, 1'b0, 3'h7};
    go(2);
    cnt(2, n);
    chk(n, 513);
    clr(5'h02);
    @(posedge clk_sys);
    pk_op <= {SAS_PK_RSA_DEC, 1'b0, 3'h4};
    go(2);
    #1;
    chk({cmd_reject, pk_busy}, 2'b10);
    i_sas_cpu_model.access(1'b1, 32'h4010_5FFC, 32'hA5C3_0F96, rsp, q);
    chk(rsp, 2'b01);
    i_sas_cpu_model.access(1'b0, 32'h4010_5FFC, 32'h0, rsp, q);
    chk({rsp, q}, {2'b01, 32'hA5C3_0F96});
    i_sas_cpu_model.access(1'b0, 32'h4010_6000, 32'h0, rsp, q);
    chk(rsp, 2'b10);
    i_sas_cpu_model.access(1'b0, 32'h400F_FFFC, 32'h0, rsp, q);
    chk(rsp, 2'b10);
  endtask

  task automatic t_fault();
    @(posedge clk_sys);
    pk_op <= {SAS_PK_RSA_ENC, 1'b0, 3'h1};
    go(2);
    i_sas_cpu_model.access(1'b0, 32'h4010_0000, 32'h0, rsp, q);
    chk(rsp, 2'b10);
    @(posedge clk_sys);
    pk_core_fault <= 1'b1;
    cnt(2, n);
    @(posedge clk_sys);
    pk_core_fault <= 1'b0;
    chk(n, 2);
    clr(5'h01);
  endtask

  task automatic t_lp();
    @(posedge clk_sys);
    lp_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(lp_ack, 1'b1);
    @(posedge clk_sys);
    cipher_cfg <= {1'b1, SAS_KEY_128, SAS_MODE_ECB};
    go(0);
    #1;
    chk({cmd_reject, cipher_busy}, 2'b10);
    @(posedge clk_sys);
    lp_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(lp_ack, 1'b0);
  endtask

  task automatic t_rng();
    @(posedge clk_sys);
    rng_enable <= 1'b1;
    n = 0;
    while (evt_flags[4] !== 1'b1 && n < 9000) begin
      @(posedge clk_sys);
      n++;
      #1;
    end
    @(posedge clk_sys);
    rng_enable <= 1'b0;
    chk(n >= 8186 && n <= 8193, 1'b1);
    rng_rd <= 1'b1;
    n = 0;
    #1;
    while (rng_valid === 1'b1 && n < 40) begin
      chk(rng_word == 32'h5555_5555 || rng_word == 32'hAAAA_AAAA, 1'b1);
      @(posedge clk_sys);
      n++;
      #1;
    end
    @(posedge clk_sys);
    rng_rd <= 1'b0;
    chk(n, 32);
    clr(5'h10);
  endtask

  task automatic t_reset();
    @(posedge clk_sys);
    pk_op <= {SAS_PK_RSA_ENC, 1'b0, 3'h3};
    go(2);
    repeat (20) @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk({pk_busy, evt_flags, lp_ack}, 7'h0);
    chk(ctr_value[63:32], 32'h0000_0005);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    battery_reset <= 1'b0;
    t_ctr();
    t_cipher();
    t_hash();
    t_pk();
    t_fault();
    t_lp();
    t_rng();
    t_reset();
    print_verdict();
  end

  // Whole run needs about 10000 cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end
endmodule // tb
